//--- include/rss_pkg.sv
// constants and types shared by the reset source sequencer
package rss_pkg;

    localparam int CLK_MHZ     = 200;
    localparam int BIAS_US     = 10;
    localparam int BIAS_CYC    = BIAS_US * CLK_MHZ;
    localparam int XTAL_US     = 100;
    localparam int XTAL_CYC    = XTAL_US * CLK_MHZ;
    localparam int POWERUP_TIMER_A_MS   = 4;
    localparam int POWERUP_TIMER_B_MS   = 16;
    localparam int POWERUP_TIMER_C_MS   = 64;
    localparam int POWERUP_TIMER_A_CYC  = POWERUP_TIMER_A_MS * CLK_MHZ * 1000;
    localparam int POWERUP_TIMER_B_CYC  = POWERUP_TIMER_B_MS * CLK_MHZ * 1000;
    localparam int POWERUP_TIMER_C_CYC  = POWERUP_TIMER_C_MS * CLK_MHZ * 1000;
    localparam int FILT_CYC    = 8;
    localparam int CNT_W       = 24;
    localparam int FILT_W      = 8;

    localparam logic [7:0]  OFS_OSC_CFG   = 8'h00;
    localparam logic [7:0]  OFS_PWR_CFG   = 8'h04;
    localparam logic [7:0]  OFS_RST_FLAGS = 8'h08;
    localparam logic [7:0]  OFS_STATUS    = 8'h0C;

    localparam int CFG_FPR_LSB   = 0;
    localparam int CFG_FOS_LSB   = 8;
    localparam int CFG_CLK_SWITCH_MONITOR_SEL_LSB = 14;
    localparam logic [23:0] CFG_MASK  = 24'h00C71F;
    localparam logic [23:0] CFG_RST   = 24'h00C300;
    localparam logic [1:0]  CLK_SWITCH_MONITOR_SEL_MON_ON = 2'h0;
    localparam logic [2:0]  FOS_FAST_RC  = 3'h1;

    localparam int PWR_SEL_LSB  = 0;
    localparam int PWR_XTAL_BIT = 2;
    localparam int PWR_PLL_BIT  = 3;
    localparam logic [3:0]  PWR_RST = 4'h0;

    localparam int FLG_POR   = 0;
    localparam int FLG_BOR   = 1;
    localparam int FLG_IDLE  = 2;
    localparam int FLG_SLEEP = 3;
    localparam int FLG_WDTO  = 4;
    localparam int FLG_SWR   = 6;
    localparam int FLG_EXTR  = 7;
    localparam int FLG_IOP   = 14;
    localparam int FLG_TRAP  = 15;
    localparam logic [15:0] FLG_MASK = 16'hC0DF;
    localparam logic [15:0] FLG_RST  = 16'h0003;

    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;

    typedef enum logic [2:0] {
        SEQ_BIAS    = 3'h0,
        SEQ_PWRUP   = 3'h1,
        SEQ_XTAL    = 3'h2,
        SEQ_CLKWAIT = 3'h3,
        SEQ_PHASE   = 3'h4,
        SEQ_RUN     = 3'h5,
        SEQ_PINHOLD = 3'h6
    } rss_seq_t;

    typedef struct packed {
        logic por;
        logic bor;
        logic wdt;
        logic swr;
        logic trap;
        logic iop;
    } rss_cause_t;

    typedef struct packed {
        rss_seq_t          state;
        logic [CNT_W-1:0]  cnt;
        logic [FILT_W-1:0] filt_cnt;
        logic              pin_low;
        logic              sys_rst;
        logic              fast_rc;
        logic              trap_p;
        logic              vec_p;
        logic              wake_p;
        logic              ost_p;
        logic [23:0]       cfg;
        logic [3:0]        pwr;
        logic [15:0]       flags;
        logic [2:0]        sel_grp;
        logic [4:0]        sel_prim;
        logic              aw_got;
        logic [7:0]        aw_addr;
        logic              w_got;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } rss_state_t;

endpackage

//--- logic/rss_top.sv
// reset source sequencer with axi4-lite register access
//
// Overview of operation
// - each cause sets its own flag.
// - watchdog in sleep wakes, no reset.
// - pin filter drops short pulses.
// - reset pin never driven.
// - power-on clears timers, resets, picks configured clock.
// - power-on runs 10 us bias-settle delay first.
// - then power-up delay: none, 4, 16 or 64 ms.
// - release on next first-phase edge; vector loads.
// - monitor on, delays done, clock bad: clock failure trap.
// - trap switches to fast rc oscillator.
// - monitor and power-up timer off: prompt release.
// - monitor off, no clock: reset held until clock.
// - brown-out resets, reselects clock from config.
// - brown-out starts start-up timer; clock held until ready, locked.
// - brown-out runs bias-settle and power-up delays.
// - zero delay with crystal: 100 us crystal-settle delay.
// - brown-out sets flag bit 1 of reset control register.
// - brown-out acts in sleep and idle.
// - config: primary select bits 4..0, group bits 10..8.
// - flags read/write; events set their own, power-on also sets the brown-out flag.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps

module rss_top #(
    parameter int          POWERUP_TIMER_A_CYC = rss_pkg::POWERUP_TIMER_A_CYC,
    parameter int          POWERUP_TIMER_B_CYC = rss_pkg::POWERUP_TIMER_B_CYC,
    parameter int          POWERUP_TIMER_C_CYC = rss_pkg::POWERUP_TIMER_C_CYC,
    parameter int          XTAL_CYC   = rss_pkg::XTAL_CYC,
    parameter int          FILT_CYC   = rss_pkg::FILT_CYC,
    parameter logic [23:0] CFG_INIT   = rss_pkg::CFG_RST
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    input  wire rss_pkg::rss_cause_t cause,
    input  wire logic                ext_reset_pin_n,
    output logic                     ext_reset_pin_o,
    output logic                     ext_reset_pin_oe,
    input  wire logic                sleep_mode,
    input  wire logic                idle_mode,
    input  wire logic                osc_running,
    input  wire logic                osc_startup_done,
    input  wire logic                pll_lock,
    input  wire logic                first_phase_clock,
    output logic                     system_reset_line,
    output logic                     reset_vector_load,
    output logic                     clock_fail_trap,
    output logic                     watchdog_wake,
    output logic                     osc_startup_start,
    output logic                     fast_rc_osc_sel,
    output logic [2:0]               osc_group_sel,
    output logic [4:0]               primary_osc_sel
);

    localparam int CW = rss_pkg::CNT_W;
    localparam int FW = rss_pkg::FILT_W;

    initial
    begin
        if (POWERUP_TIMER_A_CYC < 1 || POWERUP_TIMER_B_CYC < 1 || POWERUP_TIMER_C_CYC < 1 || XTAL_CYC < 1)
            $error("delay too short");
        if (POWERUP_TIMER_C_CYC >= (1 << CW) || POWERUP_TIMER_B_CYC >= (1 << CW)
            || POWERUP_TIMER_A_CYC >= (1 << CW) || XTAL_CYC >= (1 << CW))
            $error("delay too long");
        if (FILT_CYC < 1 || FILT_CYC >= (1 << FW))
            $error("filter length out of range");
    end

    rss_pkg::rss_state_t s_r;
    rss_pkg::rss_state_t s_nxt;

    logic             clk_ok;
    logic             mon_on;
    logic             pin_fall;
    logic [CW-1:0]    powerup_timer_last;
    logic [15:0]      flag_set;
    logic             do_wr;
    logic [31:0]      rd_word;
    logic             rd_hit;
    logic [31:0]      bmask;

    // last count of power-up delay
    function automatic logic [CW-1:0] powerup_timer_end(input logic [1:0] sel);
        logic [CW-1:0] v;
        v = '0;
        case (sel)
            2'h1:    v = CW'(POWERUP_TIMER_A_CYC - 1);
            2'h2:    v = CW'(POWERUP_TIMER_B_CYC - 1);
            2'h3:    v = CW'(POWERUP_TIMER_C_CYC - 1);
            default: v = '0;
        endcase
        return v;
    endfunction

    assign ext_reset_pin_o  = 1'b0;
    assign ext_reset_pin_oe = 1'b0;

    assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;

    assign system_reset_line = s_r.sys_rst;
    assign reset_vector_load = s_r.vec_p;
    assign clock_fail_trap   = s_r.trap_p;
    assign watchdog_wake     = s_r.wake_p;
    assign osc_startup_start = s_r.ost_p;
    assign fast_rc_osc_sel   = s_r.fast_rc;
    assign osc_group_sel     = s_r.fast_rc ? rss_pkg::FOS_FAST_RC : s_r.sel_grp;
    assign primary_osc_sel   = s_r.sel_prim;

    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.trap_p = 1'b0;
        s_nxt.vec_p  = 1'b0;
        s_nxt.wake_p = 1'b0;
        s_nxt.ost_p  = 1'b0;
        flag_set   = '0;
        rd_word    = '0;
        rd_hit     = 1'b0;
        bmask      = '0;
        do_wr      = 1'b0;

        // usable clock
        clk_ok = osc_running && osc_startup_done
                 && (!s_r.pwr[rss_pkg::PWR_PLL_BIT] || pll_lock);
        mon_on = s_r.cfg[rss_pkg::CFG_CLK_SWITCH_MONITOR_SEL_LSB +: 2] == rss_pkg::CLK_SWITCH_MONITOR_SEL_MON_ON;
        powerup_timer_last = powerup_timer_end(s_r.pwr[rss_pkg::PWR_SEL_LSB +: 2]);

        // pin filter
        pin_fall = 1'b0;
        if (ext_reset_pin_n == s_r.pin_low)
        begin
            if (s_r.filt_cnt == FW'(FILT_CYC - 1))
            begin
                s_nxt.pin_low  = !s_r.pin_low;
                s_nxt.filt_cnt = '0;
                pin_fall       = !s_r.pin_low;
            end
            else
            begin
                s_nxt.filt_cnt = s_r.filt_cnt + FW'(1);
            end
        end
        else
        begin
            s_nxt.filt_cnt = '0;
        end

        // release sequence
        case (s_r.state)
            rss_pkg::SEQ_BIAS:
            begin
                s_nxt.cnt = s_r.cnt + CW'(1);
                if (s_r.cnt == CW'(rss_pkg::BIAS_CYC - 1))
                begin
                    s_nxt.cnt = '0;
                    if (s_r.pwr[rss_pkg::PWR_SEL_LSB +: 2] != 2'h0)
                        s_nxt.state = rss_pkg::SEQ_PWRUP;
                    else if (s_r.pwr[rss_pkg::PWR_XTAL_BIT])
                        s_nxt.state = rss_pkg::SEQ_XTAL;
                    else if (clk_ok)
                        s_nxt.state = rss_pkg::SEQ_PHASE;
                    else if (mon_on)
                    begin
                        s_nxt.trap_p  = 1'b1;
                        s_nxt.fast_rc = 1'b1;
                        s_nxt.state   = rss_pkg::SEQ_PHASE;
                    end
                    else
                        s_nxt.state = rss_pkg::SEQ_CLKWAIT;
                end
            end
            rss_pkg::SEQ_PWRUP, rss_pkg::SEQ_XTAL:
            begin
                s_nxt.cnt = s_r.cnt + CW'(1);
                if ((s_r.state == rss_pkg::SEQ_PWRUP && s_r.cnt == powerup_timer_last)
                    || (s_r.state == rss_pkg::SEQ_XTAL
                        && s_r.cnt == CW'(XTAL_CYC - 1)))
                begin
                    s_nxt.cnt = '0;
                    if (clk_ok)
                        s_nxt.state = rss_pkg::SEQ_PHASE;
                    else if (mon_on)
                    begin
                        s_nxt.trap_p  = 1'b1;
                        s_nxt.fast_rc = 1'b1;
                        s_nxt.state   = rss_pkg::SEQ_PHASE;
                    end
                    else
                        s_nxt.state = rss_pkg::SEQ_CLKWAIT;
                end
            end
            rss_pkg::SEQ_CLKWAIT:
            begin
                if (clk_ok)
                    s_nxt.state = rss_pkg::SEQ_PHASE;
            end
            rss_pkg::SEQ_PHASE:
            begin
                if (first_phase_clock)
                begin
                    s_nxt.sys_rst = 1'b0;
                    s_nxt.vec_p   = 1'b1;
                    s_nxt.state   = rss_pkg::SEQ_RUN;
                end
            end
            rss_pkg::SEQ_RUN:
            begin
                s_nxt.sys_rst = 1'b0;
            end
            rss_pkg::SEQ_PINHOLD:
            begin
                if (!s_r.pin_low)
                begin
                    s_nxt.fast_rc = 1'b0;
                    s_nxt.state   = rss_pkg::SEQ_CLKWAIT;
                end
            end
            default:
            begin
                s_nxt.state   = rss_pkg::SEQ_BIAS;
                s_nxt.cnt     = '0;
                s_nxt.sys_rst = 1'b1;
            end
        endcase

        // internal causes; later ones win
        if (cause.wdt)
        begin
            flag_set[rss_pkg::FLG_WDTO] = 1'b1;
            if (sleep_mode)
            begin
                s_nxt.wake_p = 1'b1;
                flag_set[rss_pkg::FLG_SLEEP] = 1'b1;
            end
        end
        if ((cause.wdt && !sleep_mode) || cause.swr || cause.trap || cause.iop)
        begin
            s_nxt.sys_rst = 1'b1;
            s_nxt.cnt     = '0;
            s_nxt.fast_rc = 1'b0;
            s_nxt.state   = rss_pkg::SEQ_CLKWAIT;
        end
        flag_set[rss_pkg::FLG_SWR]  = cause.swr;
        flag_set[rss_pkg::FLG_TRAP] = cause.trap;
        flag_set[rss_pkg::FLG_IOP]  = cause.iop;

        if (pin_fall)
        begin
            flag_set[rss_pkg::FLG_EXTR]  = 1'b1;
            flag_set[rss_pkg::FLG_SLEEP] = sleep_mode;
            flag_set[rss_pkg::FLG_IDLE]  = idle_mode;
        end
        if (s_nxt.pin_low)
        begin
            s_nxt.sys_rst = 1'b1;
            s_nxt.cnt     = '0;
            s_nxt.state   = rss_pkg::SEQ_PINHOLD;
        end

        // power events win in every mode
        if (cause.bor || cause.por)
        begin
            s_nxt.sys_rst  = 1'b1;
            s_nxt.cnt      = '0;
            s_nxt.state    = rss_pkg::SEQ_BIAS;
            s_nxt.fast_rc  = 1'b0;
            s_nxt.sel_grp  = s_r.cfg[rss_pkg::CFG_FOS_LSB +: 3];
            s_nxt.sel_prim = s_r.cfg[rss_pkg::CFG_FPR_LSB +: 5];
            s_nxt.ost_p    = s_r.pwr[rss_pkg::PWR_XTAL_BIT];
            flag_set[rss_pkg::FLG_BOR] = 1'b1;
        end
        if (cause.por)
            flag_set[rss_pkg::FLG_POR] = 1'b1;

        // write: address and data in any order
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_nxt.w_got  = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        for (int i = 0; i < 4; i++)
            bmask[i*8 +: 8] = {8{s_r.w_strb[i]}};
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
        begin
            do_wr         = 1'b1;
            s_nxt.aw_got  = 1'b0;
            s_nxt.w_got   = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = rss_pkg::RESP_OK;
            case (s_r.aw_addr & 8'hFC)
                rss_pkg::OFS_OSC_CFG:
                    s_nxt.cfg = ((s_r.cfg & ~bmask[23:0])
                                | (s_r.w_data[23:0] & bmask[23:0]))
                                & rss_pkg::CFG_MASK;
                rss_pkg::OFS_PWR_CFG:
                    s_nxt.pwr = (s_r.pwr & ~bmask[3:0]) | (s_r.w_data[3:0] & bmask[3:0]);
                rss_pkg::OFS_RST_FLAGS:
                    s_nxt.flags = ((s_r.flags & ~bmask[15:0])
                                  | (s_r.w_data[15:0] & bmask[15:0]))
                                  & rss_pkg::FLG_MASK;
                rss_pkg::OFS_STATUS:
                    s_nxt.bresp = rss_pkg::RESP_OK;
                default:
                    s_nxt.bresp = rss_pkg::RESP_ERR;
            endcase
        end
        if (s_r.bvalid && s_axi_bready)
            s_nxt.bvalid = 1'b0;

        // events win over a write
        s_nxt.flags = s_nxt.flags | (flag_set & rss_pkg::FLG_MASK);

        // read: answer one cycle later
        case (s_axi_araddr & 8'hFC)
            rss_pkg::OFS_OSC_CFG:
            begin
                rd_word = {8'h00, s_r.cfg};
                rd_hit  = 1'b1;
            end
            rss_pkg::OFS_PWR_CFG:
            begin
                rd_word = {28'h0000000, s_r.pwr};
                rd_hit  = 1'b1;
            end
            rss_pkg::OFS_RST_FLAGS:
            begin
                rd_word = {16'h0000, s_r.flags};
                rd_hit  = 1'b1;
            end
            rss_pkg::OFS_STATUS:
            begin
                rd_word = {11'h000, s_r.sel_prim, 5'h00, s_r.sel_grp,
                           1'b0, clk_ok, s_r.pin_low, s_r.fast_rc,
                           s_r.sys_rst, s_r.state};
                rd_hit  = 1'b1;
            end
            default:
            begin
                rd_word = '0;
                rd_hit  = 1'b0;
            end
        endcase
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = rd_word;
            s_nxt.rresp  = rd_hit ? rss_pkg::RESP_OK : rss_pkg::RESP_ERR;
        end
        else if (s_r.rvalid && s_axi_rready)
        begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r          <= '0;
            s_r.state    <= rss_pkg::SEQ_BIAS;
            s_r.sys_rst  <= 1'b1;
            s_r.cfg      <= CFG_INIT & rss_pkg::CFG_MASK;
            s_r.pwr      <= rss_pkg::PWR_RST;
            s_r.flags    <= rss_pkg::FLG_RST;
            s_r.sel_grp  <= CFG_INIT[rss_pkg::CFG_FOS_LSB +: 3];
            s_r.sel_prim <= CFG_INIT[rss_pkg::CFG_FPR_LSB +: 5];
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule // rss_top

//--- testbench/rss_osc_model.sv
// oscillator circuit and clock phase model on the far side of the sequencer
`timescale 1ns/100ps
module rss_osc_model (
    input  wire logic aclk,
    input  wire logic clk_good,
    output logic      osc_running,
    output logic      osc_startup_done,
    output logic      pll_lock,
    output logic      first_phase_clock
);
    logic [1:0] ph_r = 2'h0;
    logic       ok_r = 1'b0;
    // phase pulse one cycle in four; clock status follows one cycle late
    always_ff @(posedge aclk)
    begin
        ph_r <= ph_r + 2'h1;
        ok_r <= clk_good;
    end
    assign osc_running       = ok_r;
    assign osc_startup_done  = ok_r;
    assign pll_lock          = ok_r;
    assign first_phase_clock = (ph_r == 2'h3);
endmodule // rss_osc_model

//--- testbench/rss_monitor.sv
// port assertions for the reset source sequencer
`timescale 1ns/100ps
module rss_monitor (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire rss_pkg::rss_cause_t cause,
    input wire logic                ext_reset_pin_n,
    input wire logic                ext_reset_pin_o,
    input wire logic                ext_reset_pin_oe,
    input wire logic                sleep_mode,
    input wire logic                osc_running,
    input wire logic                osc_startup_done,
    input wire logic                pll_lock,
    input wire logic                first_phase_clock,
    input wire logic                system_reset_line,
    input wire logic                reset_vector_load,
    input wire logic                clock_fail_trap,
    input wire logic                watchdog_wake,
    input wire logic                fast_rc_osc_sel,
    input wire logic [2:0]          osc_group_sel
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] hi_r;
    logic [15:0] hi_nxt;
    logic [3:0]  lo_r;
    logic [3:0]  lo_nxt;
    wire         clk_all = osc_running && osc_startup_done && pll_lock;
    // cycles since power event, pin low
    always_comb
    begin
        hi_nxt = (hi_r == 16'hFFFF) ? hi_r : hi_r + 16'h1;
        lo_nxt = (lo_r == 4'hF) ? lo_r : lo_r + 4'h1;
        if (cause.por || cause.bor || !aresetn)
            hi_nxt = 16'h0;
        if (ext_reset_pin_n)
            lo_nxt = 4'h0;
    end
    always_ff @(posedge aclk)
    begin
        hi_r <= hi_nxt;
        lo_r <= lo_nxt;
    end
    a_pin_not_driven: assert property (!ext_reset_pin_oe && !ext_reset_pin_o)
        else $error("reset pin driven");
    a_short_pulse_ignored: assert property ($rose(system_reset_line) |->
        $past(cause) != 6'h00 || lo_r >= 4'h8) else $error("reset without cause");
    a_bias_before_release: assert property ($fell(system_reset_line) |->
        hi_r >= 16'(rss_pkg::BIAS_CYC - 2)) else $error("early release");
    a_release_on_phase: assert property ($fell(system_reset_line) |->
        $past(first_phase_clock) && reset_vector_load) else $error("release off phase");
    a_power_enters_reset: assert property (cause.por || cause.bor |=>
        system_reset_line [*8]) else $error("no power reset");
    a_pin_low_holds: assert property ((!ext_reset_pin_n) [*8] ##1
        (!ext_reset_pin_n) [*4] |-> system_reset_line) else $error("pin low, no reset");
    a_trap_bad_clock: assert property (clock_fail_trap |-> !$past(clk_all))
        else $error("bad trap");
    a_trap_fast_rc: assert property (clock_fail_trap |=> fast_rc_osc_sel &&
        osc_group_sel == rss_pkg::FOS_FAST_RC) else $error("no fast rc");
    a_wake_no_reset: assert property (cause == 6'h08 && sleep_mode &&
        ext_reset_pin_n && !system_reset_line |=> watchdog_wake && !system_reset_line)
        else $error("watchdog wake reset");
    c_release: cover property ($fell(system_reset_line));
    c_trap: cover property (clock_fail_trap);
    c_wake: cover property (watchdog_wake);
endmodule // rss_monitor

bind rss_top rss_monitor rss_monitor_i (.*);

//--- testbench/rss_top_test.sv
// self-checking bench for the reset source sequencer
`timescale 1ns/100ps
module rss_top_test;
    localparam int         PA = 100;
    localparam int         PB = 300;
    localparam int         PC = 600;
    localparam int         XT = 50;
    localparam int         BC = rss_pkg::BIAS_CYC;
    localparam logic [7:0] FL = rss_pkg::OFS_RST_FLAGS;
    localparam logic [7:0] OC = rss_pkg::OFS_OSC_CFG;
    logic                aclk = 1'b0, aresetn = 1'b0, pin_n = 1'b1, slp = 1'b0, idl = 1'b0;
    logic                good = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [7:0]          aa = 8'h00;
    logic [31:0]         wd = 32'h0, q, rdata;
    logic [1:0]          r, bresp, rresp;
    rss_pkg::rss_cause_t cs = 6'h00;
    logic                awr, wrdy, bv, arr, rv, osc, sud, pll, fpc, srl, trap, wake, fast_rc_osc, osc_startup_timer;
    logic [2:0]          grp;
    logic [4:0]          prim;
    int                  error_cnt = 0, n_checks = 0, n;
    rss_top #(.POWERUP_TIMER_A_CYC(PA), .POWERUP_TIMER_B_CYC(PB), .POWERUP_TIMER_C_CYC(PC), .XTAL_CYC(XT)) rss_top_i (
        .aclk, .aresetn, .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(aa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(aa),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .cause(cs), .ext_reset_pin_n(pin_n), .ext_reset_pin_o(),
        .ext_reset_pin_oe(), .sleep_mode(slp), .idle_mode(idl), .osc_running(osc),
        .osc_startup_done(sud), .pll_lock(pll), .first_phase_clock(fpc),
        .system_reset_line(srl), .reset_vector_load(), .clock_fail_trap(trap),
        .watchdog_wake(wake), .osc_startup_start(osc_startup_timer), .fast_rc_osc_sel(fast_rc_osc),
        .osc_group_sel(grp), .primary_osc_sel(prim));
    rss_osc_model rss_osc_model_i (.aclk(aclk), .clk_good(good), .osc_running(osc),
        .osc_startup_done(sud), .pll_lock(pll), .first_phase_clock(fpc));
    always #2.5 aclk = ~aclk;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo(input int k, input int lim);
        if (k >= lim)
        begin
            error_cnt++;
            $display("[FAIL] %0t wait ran out", $time);
            stop_test();
        end
    endtask
    // one register access
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tr, dn;
        dn = 1'b0;
        @(posedge aclk);
        awv <= w;
        wv  <= w;
        arv <= !w;
        aa  <= a;
        wd  <= d;
        br  <= w;
        rr  <= !w;
        for (int k = 0; k < 64 && !dn; k++)
        begin
            @(negedge aclk);
            ta = awv && awr;
            tw = wv && wrdy;
            tr = arv && arr;
            dn = w ? bv : rv;
            q  = rdata;
            r  = w ? bresp : rresp;
            @(posedge aclk);
            if (ta)
                awv <= 1'b0;
            if (tw)
                wv <= 1'b0;
            if (tr)
                arv <= 1'b0;
        end
        tmo(dn ? 0 : 64, 64);
        br <= 1'b0;
        rr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic hit(input logic [5:0] c);
        @(posedge aclk);
        cs <= c;
        @(posedge aclk);
        cs <= 6'h00;
        @(negedge aclk);
    endtask
    task automatic rel(input int lim);
        for (n = 0; n < lim && srl !== 1'b0; n++)
            @(negedge aclk);
        tmo(n, lim);
    endtask
    task automatic t_regs;
        rd(FL, 32'h3);
        rd(OC, 32'hC300);
        bus(1'b0, 8'h10, 32'h0);
        chk(r, rss_pkg::RESP_ERR);
    endtask
    // each delay choice, then brown-out with crystal
    task automatic t_delay;
        int e;
        int dly[5] = '{0, PA, PB, PC, XT};
        for (int s = 0; s < 5; s++)
        begin
            e = BC + dly[s];
            bus(1'b1, rss_pkg::OFS_PWR_CFG, (s == 4) ? 32'h4 : 32'(s));
            bus(1'b1, OC, 32'hC300 + 32'(s));
            bus(1'b1, FL, 32'h0);
            hit((s == 4) ? 6'h10 : 6'h20);
            chk(osc_startup_timer, s == 4);
            rel(e + 20);
            chk(n + 6 > e && n < e + 8, 1'b1);
            rd(FL, (s == 4) ? 32'h2 : 32'h3);
            chk({grp, prim}, {3'h3, 5'(s)});
        end
    endtask
    task automatic t_pin;
        bus(1'b1, FL, 32'h0);
        idl   <= 1'b1;
        pin_n <= 1'b0;
        repeat (3) @(posedge aclk);
        pin_n <= 1'b1;
        repeat (20) @(posedge aclk);
        chk(srl, 1'b0);
        pin_n <= 1'b0;
        repeat (30) @(posedge aclk);
        chk(srl, 1'b1);
        pin_n <= 1'b1;
        idl   <= 1'b0;
        rel(40);
        rd(FL, 32'h84);
    endtask
    // flags accumulate
    task automatic t_causes;
        logic [5:0]  c[4] = '{6'h04, 6'h02, 6'h01, 6'h08};
        logic [15:0] f[4] = '{16'h40, 16'h8040, 16'hC040, 16'hC050};
        bus(1'b1, FL, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            hit(c[i]);
            chk(srl, 1'b1);
            rel(40);
            rd(FL, 32'(f[i]));
        end
        slp <= 1'b1;
        hit(6'h08);
        chk({wake, srl}, 2'h2);
        slp <= 1'b0;
        rd(FL, 32'hC058);
    endtask
    task automatic t_clock;
        bus(1'b1, rss_pkg::OFS_PWR_CFG, 32'h0);
        bus(1'b1, OC, 32'h0305);
        good <= 1'b0;
        hit(6'h20);
        for (n = 0; n < BC + 20 && trap !== 1'b1; n++)
            @(negedge aclk);
        tmo(n, BC + 20);
        @(posedge aclk);
        chk({fast_rc_osc, grp}, {1'b1, rss_pkg::FOS_FAST_RC});
        rel(20);
        bus(1'b1, OC, 32'hC305);
        hit(6'h20);
        repeat (BC + 500) @(posedge aclk);
        chk({srl, grp}, 4'hB);
        good <= 1'b1;
        rel(20);
    endtask
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_delay();
        t_pin();
        t_causes();
        t_clock();
        stop_test();
    end
endmodule // rss_top_test
